/* logic/ccsr_bank_regs.vh */
// Purpose: Constants for the core control/status register bank.
// Assumes: 12-bit register numbers and 32-bit data.
// Notes:   Definitions only.
`ifndef CCSR_BANK_REGS_VH
`define CCSR_BANK_REGS_VH

// ***************************************************************
// Register numbers
// ***************************************************************
`define CCSR_A_ISA          12'h301
`define CCSR_A_IRQ_EN       12'h304
`define CCSR_A_CAUSE        12'h342
`define CCSR_A_IRQ_PEND     12'h344
`define CCSR_A_REGION_ACC   12'h7c0
`define CCSR_A_PAUSE_CTL    12'h7c2
`define CCSR_A_MEM_SYNC     12'h7c4
`define CCSR_A_POWER_CTL    12'h7c6
`define CCSR_A_IC_SELECT    12'h7c8
`define CCSR_A_IC_DATA_LO   12'h7c9
`define CCSR_A_IC_DATA_HI   12'h7ca
`define CCSR_A_IC_TRIGGER   12'h7cb
`define CCSR_A_PERF_GROUP   12'h7d0
`define CCSR_A_IC_ERR_CNT   12'h7f0
`define CCSR_A_IM_ERR_CNT   12'h7f1
`define CCSR_A_DM_ERR_CNT   12'h7f2
`define CCSR_A_CLK_GATE     12'h7f8
`define CCSR_A_FEAT_DIS     12'h7f9
`define CCSR_A_BERR_UNLOCK  12'hbc0
`define CCSR_A_XI_VTABLE    12'hbc8
`define CCSR_A_XI_THRESH    12'hbc9
`define CCSR_A_XI_CAPTURE   12'hbca
`define CCSR_A_XI_CLAIM_PL  12'hbcb
`define CCSR_A_XI_CUR_PL    12'hbcc
`define CCSR_A_VENDOR       12'hf11
`define CCSR_A_ARCH         12'hf12
`define CCSR_A_IMPL         12'hf13
`define CCSR_A_HART         12'hf14
`define CCSR_A_BERR_ADDR    12'hfc0
`define CCSR_A_XI_HANDLER   12'hfc8

// ***************************************************************
// Field layouts, masks and reset values
// ***************************************************************
`define CCSR_CG_MASK        32'h0000_01ff
`define CCSR_CG_RESET       32'h0000_0000
`define CCSR_FD_MASK        32'h0007_05fd
`define CCSR_FD_RESET       32'h0007_0000
`define CCSR_FD_QOS_HI      18
`define CCSR_FD_QOS_LO      16
`define CCSR_IE_MASK        32'h4000_0888
`define CCSR_IP_MASK        32'h4000_0880
`define CCSR_BIT_CE         30
`define CCSR_BIT_EXT        11
`define CCSR_BIT_TMR        7
`define CCSR_ISA_VALUE      32'h4000_1104
`define CCSR_HART_VALUE     32'h0000_0000
`define CCSR_SLOTS          18
`define CCSR_SLOT_NONE      5'h1f

// ***************************************************************
// Trap cause encodings
// ***************************************************************
`define CCSR_C_NMI_PIN      32'h0000_0000
`define CCSR_C_NMI_STORE    32'hf000_0000
`define CCSR_C_NMI_LOAD     32'hf000_0001
`define CCSR_C_IRQ_TMR      32'h8000_0007
`define CCSR_C_IRQ_EXT      32'h8000_000b
`define CCSR_C_IRQ_CE       32'h8000_001e
`define CCSR_C_EXC_IFAULT   32'h0000_0001
`define CCSR_C_EXC_ILLEGAL  32'h0000_0002
`define CCSR_C_EXC_BRK      32'h0000_0003
`define CCSR_C_EXC_LMIS     32'h0000_0004
`define CCSR_C_EXC_LFAULT   32'h0000_0005
`define CCSR_C_EXC_SMIS     32'h0000_0006
`define CCSR_C_EXC_SFAULT   32'h0000_0007
`define CCSR_C_EXC_ECALL    32'h0000_000b

`endif

/* logic/ccsr_bank.v */
// Purpose: Machine-mode control/status register bank of a 32-bit core.
// Assumes: One core clock; all inputs synchronous to it.
// Notes:   Accesses answer one cycle after the request.
// Contract
// - Nine clock gating override bits, 1 keeps running.
// - Override bits reset to zero.
// - Reserved and unused bits read zero.
// - Read/write registers accept anything, read legal.
// - Enables at bits 30, 11, 7, 3.
// - Software enable stored but has no effect.
// - Read-only pending bits 30, 11, 7, reset zero.
// - No supervisor or user enable/pending bits.
// - Trap cause holds only legal encodings.
// - Exception causes 1-7 and 11, top clear.
// - Interrupt causes 7, 11, 30 with bit 31.
// - NMI causes zero, f0000000, f0000001.
// - Reserved cause values never produced.
// - ISA register constant, writes ignored.
// - Identity registers read-only constants, thread zero.
// - Sync trigger and cache access debug-only.
// - Bus error address and handler pointer read-only.
// - Decode region, pause, power, perf, error counters.
// - Decode unlock and external interrupt registers.
// - Debug-only access outside debug mode is illegal.
// - DMA QoS field 18:16 resets to seven.
`timescale 1ns/1ps
`default_nettype none
`include "ccsr_bank_regs.vh"

module ccsr_bank #(
   parameter [31:0] VENDOR_ID = 32'h0000_0a5a, // Arbitrary value.
   parameter [31:0] ARCH_ID   = 32'h0000_00c3, // Arbitrary value.
   parameter [31:0] IMPL_ID   = 32'h0000_0002  // Arbitrary value.
) (
   input  wire        mclk_i,
   input  wire        rst_b_i,
   input  wire        csr_req_i,
   input  wire        csr_we_i,
   input  wire [11:0] csr_addr_i,
   input  wire [31:0] csr_wdata_i,
   input  wire        debug_mode_i,
   output reg         csr_ack_o,
   output reg  [31:0] csr_rdata_o,
   output reg         csr_illegal_o,
   input  wire        timer_irq_i,
   input  wire        ext_irq_i,
   input  wire        ce_irq_i,
   output wire        irq_req_o,
   input  wire        irq_take_i,
   input  wire        exc_valid_i,
   input  wire [3:0]  exc_code_i,
   input  wire        nmi_pin_i,
   input  wire        nmi_store_err_i,
   input  wire        nmi_load_err_i,
   input  wire [31:0] bus_err_addr_i,
   input  wire [31:0] irq_handler_ptr_i,
   output wire [8:0]  clk_gate_override_o,
   output wire [31:0] feature_disable_o,
   output wire [2:0]  dma_qos_o
);

   // ***************************************************************
   // Decode helpers
   // ***************************************************************

   // Slot in the plain storage array for the pass-through registers.
   function [4:0] csr_slot;
      input [11:0] a;
      begin
         case (a)
            `CCSR_A_REGION_ACC:  csr_slot = 5'd0;
            `CCSR_A_PAUSE_CTL:   csr_slot = 5'd1;
            `CCSR_A_MEM_SYNC:    csr_slot = 5'd2;
            `CCSR_A_POWER_CTL:   csr_slot = 5'd3;
            `CCSR_A_IC_SELECT:   csr_slot = 5'd4;
            `CCSR_A_IC_DATA_LO:  csr_slot = 5'd5;
            `CCSR_A_IC_DATA_HI:  csr_slot = 5'd6;
            `CCSR_A_IC_TRIGGER:  csr_slot = 5'd7;
            `CCSR_A_PERF_GROUP:  csr_slot = 5'd8;
            `CCSR_A_IC_ERR_CNT:  csr_slot = 5'd9;
            `CCSR_A_IM_ERR_CNT:  csr_slot = 5'd10;
            `CCSR_A_DM_ERR_CNT:  csr_slot = 5'd11;
            `CCSR_A_BERR_UNLOCK: csr_slot = 5'd12;
            `CCSR_A_XI_VTABLE:   csr_slot = 5'd13;
            `CCSR_A_XI_THRESH:   csr_slot = 5'd14;
            `CCSR_A_XI_CAPTURE:  csr_slot = 5'd15;
            `CCSR_A_XI_CLAIM_PL: csr_slot = 5'd16;
            `CCSR_A_XI_CUR_PL:   csr_slot = 5'd17;
            default:             csr_slot = `CCSR_SLOT_NONE;
         endcase
      end
   endfunction

   // Only the defined encodings may ever sit in the cause register.
   function cause_legal;
      input [31:0] v;
      begin
         case (v)
            `CCSR_C_NMI_PIN, `CCSR_C_NMI_STORE, `CCSR_C_NMI_LOAD,
            `CCSR_C_IRQ_TMR, `CCSR_C_IRQ_EXT, `CCSR_C_IRQ_CE,
            `CCSR_C_EXC_IFAULT, `CCSR_C_EXC_ILLEGAL, `CCSR_C_EXC_BRK,
            `CCSR_C_EXC_LMIS, `CCSR_C_EXC_LFAULT, `CCSR_C_EXC_SMIS,
            `CCSR_C_EXC_SFAULT, `CCSR_C_EXC_ECALL:
               cause_legal = 1'b1;
            default:
               cause_legal = 1'b0;
         endcase
      end
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   reg [31:0] clk_gate_reg;
   reg [31:0] feat_dis_reg;
   reg [31:0] irq_en_reg;
   reg [31:0] irq_pend_reg;
   reg [31:0] cause_reg;
   reg [31:0] cause_next;
   reg [31:0] store_mem [0:`CCSR_SLOTS-1];

   reg [31:0] rd_val;
   reg        acc_bad;
   reg        wr_ok;
   wire [4:0] slot = csr_slot(csr_addr_i);
   wire       wr_req = csr_req_i & csr_we_i;

   // ***************************************************************
   // Access decode
   // ***************************************************************

   // The debug-only group shares one check so that a machine-mode access
   // never reaches the storage and is reported instead.
   wire dbg_only = (csr_addr_i == `CCSR_A_MEM_SYNC) |
                   (csr_addr_i >= `CCSR_A_IC_SELECT &&
                    csr_addr_i <= `CCSR_A_IC_TRIGGER);

   always @* begin
      rd_val  = 32'h0000_0000;
      acc_bad = 1'b0;
      case (csr_addr_i)
         `CCSR_A_ISA:       rd_val = `CCSR_ISA_VALUE;
         `CCSR_A_IRQ_EN:    rd_val = irq_en_reg & `CCSR_IE_MASK;
         `CCSR_A_CAUSE:     rd_val = cause_reg;
         `CCSR_A_IRQ_PEND: begin
            rd_val  = irq_pend_reg & `CCSR_IP_MASK;
            acc_bad = csr_we_i;
         end
         `CCSR_A_CLK_GATE:  rd_val = clk_gate_reg & `CCSR_CG_MASK;
         `CCSR_A_FEAT_DIS:  rd_val = feat_dis_reg & `CCSR_FD_MASK;
         `CCSR_A_VENDOR: begin
            rd_val  = VENDOR_ID;
            acc_bad = csr_we_i;
         end
         `CCSR_A_ARCH: begin
            rd_val  = ARCH_ID;
            acc_bad = csr_we_i;
         end
         `CCSR_A_IMPL: begin
            rd_val  = IMPL_ID;
            acc_bad = csr_we_i;
         end
         `CCSR_A_HART: begin
            rd_val  = `CCSR_HART_VALUE;
            acc_bad = csr_we_i;
         end
         `CCSR_A_BERR_ADDR: begin
            rd_val  = bus_err_addr_i;
            acc_bad = csr_we_i;
         end
         `CCSR_A_XI_HANDLER: begin
            rd_val  = irq_handler_ptr_i;
            acc_bad = csr_we_i;
         end
         default: begin
            if (slot == `CCSR_SLOT_NONE) begin
               acc_bad = 1'b1;
            end else if (dbg_only && !debug_mode_i) begin
               acc_bad = 1'b1;
            end else if (csr_addr_i == `CCSR_A_IC_TRIGGER) begin
               rd_val = 32'h0000_0000;
            end else begin
               rd_val = store_mem[slot];
            end
         end
      endcase
      wr_ok = wr_req & ~acc_bad;
   end

   // ***************************************************************
   // Answer to the pipeline
   // ***************************************************************
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         csr_ack_o     <= 1'b0;
         csr_rdata_o   <= 32'h0000_0000;
         csr_illegal_o <= 1'b0;
      end else begin
         csr_ack_o     <= csr_req_i;
         csr_illegal_o <= csr_req_i & acc_bad;
         if (csr_req_i) begin
            csr_rdata_o <= acc_bad ? 32'h0000_0000 : rd_val;
         end
      end
   end

   // ***************************************************************
   // Control registers
   // ***************************************************************
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_gate_reg <= `CCSR_CG_RESET;
         feat_dis_reg <= `CCSR_FD_RESET;
         irq_en_reg   <= 32'h0000_0000;
      end else if (wr_ok) begin
         // Unimplemented bits are dropped at the write so nothing
         // illegal is ever held.
         case (csr_addr_i)
            `CCSR_A_CLK_GATE: clk_gate_reg <= csr_wdata_i & `CCSR_CG_MASK;
            `CCSR_A_FEAT_DIS: feat_dis_reg <= csr_wdata_i & `CCSR_FD_MASK;
            `CCSR_A_IRQ_EN:   irq_en_reg <= csr_wdata_i & `CCSR_IE_MASK;
            default: begin
            end
         endcase
      end
   end

   // Plain storage words for registers whose owning units live elsewhere.
   genvar gi;
   generate
      for (gi = 0; gi < `CCSR_SLOTS; gi = gi + 1) begin : g_store
         always @(posedge mclk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               store_mem[gi] <= 32'h0000_0000;
            end else if (wr_ok && slot == gi[4:0]) begin
               store_mem[gi] <= csr_wdata_i;
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Interrupt pending and request
   // ***************************************************************
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_pend_reg <= 32'h0000_0000;
      end else begin
         irq_pend_reg <= 32'h0000_0000;
         irq_pend_reg[`CCSR_BIT_CE]  <= ce_irq_i;
         irq_pend_reg[`CCSR_BIT_EXT] <= ext_irq_i;
         irq_pend_reg[`CCSR_BIT_TMR] <= timer_irq_i;
      end
   end

   // The software enable is left out: its request is always zero.
   wire [31:0] irq_live = irq_pend_reg & irq_en_reg & `CCSR_IP_MASK;
   assign irq_req_o = |irq_live;

   // ***************************************************************
   // Trap cause
   // ***************************************************************

   // NMIs win over exceptions, exceptions over interrupt entry; among
   // interrupts external beats correctable error, which beats timer.
   always @* begin
      cause_next = cause_reg;
      if (nmi_pin_i) begin
         cause_next = `CCSR_C_NMI_PIN;
      end else if (nmi_store_err_i) begin
         cause_next = `CCSR_C_NMI_STORE;
      end else if (nmi_load_err_i) begin
         cause_next = `CCSR_C_NMI_LOAD;
      end else if (exc_valid_i && cause_legal({28'h0000_000, exc_code_i})) begin
         cause_next = {28'h0000_000, exc_code_i};
      end else if (irq_take_i && irq_live[`CCSR_BIT_EXT]) begin
         cause_next = `CCSR_C_IRQ_EXT;
      end else if (irq_take_i && irq_live[`CCSR_BIT_CE]) begin
         cause_next = `CCSR_C_IRQ_CE;
      end else if (irq_take_i && irq_live[`CCSR_BIT_TMR]) begin
         cause_next = `CCSR_C_IRQ_TMR;
      end else if (wr_ok && csr_addr_i == `CCSR_A_CAUSE &&
                   cause_legal(csr_wdata_i)) begin
         cause_next = csr_wdata_i;
      end
   end

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cause_reg <= `CCSR_C_NMI_PIN;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // ***************************************************************
   // Outputs to the core units
   // ***************************************************************
   assign clk_gate_override_o = clk_gate_reg[8:0];
   assign feature_disable_o   = feat_dis_reg;
   assign dma_qos_o           = feat_dis_reg[`CCSR_FD_QOS_HI:`CCSR_FD_QOS_LO];

endmodule

`default_nettype wire

/* dv/ccsr_bank_sva.sv */
// Purpose: Port assertions for the control/status register bank.
// Assumes: One clock, active-low asynchronous reset.
// Notes:   Attached by bind from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module ccsr_bank_sva (
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic        csr_req_i,
   input wire logic        csr_we_i,
   input wire logic [11:0] csr_addr_i,
   input wire logic [31:0] csr_wdata_i,
   input wire logic        debug_mode_i,
   input wire logic        csr_ack_o,
   input wire logic [31:0] csr_rdata_o,
   input wire logic        csr_illegal_o,
   input wire logic        timer_irq_i,
   input wire logic        ext_irq_i,
   input wire logic        ce_irq_i,
   input wire logic        irq_req_o,
   input wire logic [8:0]  clk_gate_override_o,
   input wire logic [31:0] feature_disable_o,
   input wire logic [2:0]  dma_qos_o
);
   // ********
   // Checks
   // ********
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   wire logic       rd_req = csr_req_i && !csr_we_i;
   wire logic [8:0] wd_lo  = csr_wdata_i[8:0];
   a_ack_follows: assert property ($past(csr_req_i) == csr_ack_o)
      else $error("answer strobe does not follow request");
   a_ro_write: assert property (csr_req_i && csr_we_i &&
      (csr_addr_i == 12'h344 || csr_addr_i[11:8] == 4'hf) |=> csr_illegal_o)
      else $error("write to read-only register accepted");
   a_debug_gate: assert property (csr_req_i && !debug_mode_i &&
      (csr_addr_i == 12'h7c4 || csr_addr_i[11:2] == 10'h1f2) |=> csr_illegal_o)
      else $error("debug-only register reached outside debug mode");
   a_gate_write: assert property (csr_req_i && csr_we_i && csr_addr_i == 12'h7f8
      |=> clk_gate_override_o == $past(wd_lo)) else $error("gate override not written");
   a_isa_const: assert property (rd_req && csr_addr_i == 12'h301
      |=> csr_rdata_o == 32'h4000_1104 && !csr_illegal_o) else $error("isa value wrong");
   a_hart_zero: assert property (rd_req && csr_addr_i == 12'hf14
      |=> csr_rdata_o == 32'h0000_0000) else $error("thread number not zero");
   a_qos_field: assert property (dma_qos_o == feature_disable_o[18:16])
      else $error("qos output differs from its field");
   a_fd_reserved: assert property ((feature_disable_o & ~32'h0007_05fd) == 32'h0)
      else $error("reserved feature bit set");
   a_irq_quiet: assert property (!timer_irq_i && !ext_irq_i && !ce_irq_i
      |=> !irq_req_o) else $error("interrupt request without source");
   a_enable_mask: assert property (rd_req && csr_addr_i == 12'h304
      |=> (csr_rdata_o & ~32'h4000_0888) == 32'h0) else $error("extra enable bit");
   a_illegal_zero: assert property (csr_illegal_o |-> csr_ack_o && csr_rdata_o == 32'h0)
      else $error("refused access returned data");
endmodule
`default_nettype wire

/* dv/ccsr_pipe_model.sv */
// Purpose: Pipeline side model that issues register accesses.
// Assumes: The answer arrives within four cycles of the request.
// Notes:   Released lines show inverted values so stale data never matches.
`timescale 1ns/1ps
`default_nettype none
module ccsr_pipe_model (
   input  wire logic        mclk_i,
   input  wire logic        csr_ack_i,
   input  wire logic [31:0] csr_rdata_i,
   input  wire logic        csr_illegal_i,
   output var  logic        csr_req_o = 1'b0,
   output var  logic        csr_we_o = 1'b0,
   output var  logic [11:0] csr_addr_o = 12'h0,
   output var  logic [31:0] csr_wdata_o = 32'h0
);
   // ********
   // Access
   // ********
   task automatic access(input logic we, input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] rd, output logic ill);
      int n;
      @(posedge mclk_i);
      csr_req_o   <= 1'b1;
      csr_we_o    <= we;
      csr_addr_o  <= a;
      csr_wdata_o <= d;
      @(posedge mclk_i);
      csr_req_o   <= 1'b0;
      csr_we_o    <= ~we;
      csr_addr_o  <= ~a;
      csr_wdata_o <= ~d;
      n = 0;
      while (csr_ack_i !== 1'b1 && n < 4) begin
         @(posedge mclk_i);
         n = n + 1;
      end
      rd  = (n < 4) ? csr_rdata_i : 32'hx;
      ill = (n < 4) ? csr_illegal_i : 1'bx;
   endtask
endmodule
`default_nettype wire

/* dv/tb_ccsr_bank.sv */
// Purpose: Self-checking bench for the control/status register bank.
// Assumes: Register port answers one cycle after each request.
// Notes:   Table rows first, then interrupts, traps, debug and reset.
`timescale 1ns/1ps
`default_nettype none
module tb_ccsr_bank;
   typedef struct packed {logic we; logic [11:0] a; logic [31:0] d, q; logic ill;} ccsr_row_t;
   logic mclk_i = 1'b0, rst_b_i = 1'b0, debug_mode_i = 1'b0, ill;
   logic [2:0]  irq_src = 3'h0;
   logic [4:0]  evt = 5'h0;
   logic [3:0]  code = 4'h0;
   logic [31:0] rd, berr = 32'h1357_9bdf, hptr = 32'h2468_ace0;
   wire logic        csr_req_i, csr_we_i, csr_ack_o, csr_illegal_o, irq_req_o;
   wire logic [11:0] csr_addr_i;
   wire logic [31:0] csr_wdata_i, csr_rdata_o, feature_disable_o;
   wire logic [8:0]  clk_gate_override_o;
   wire logic [2:0]  dma_qos_o;
   int n_mismatch = 0, checks_done = 0;
   ccsr_row_t rows [0:22] = '{
      '{1'b1,12'h7f8,32'hffff_ffff,32'h0,1'b0}, '{1'b0,12'h7f8,32'h0,32'h0000_01ff,1'b0},
      '{1'b1,12'h304,32'hffff_ffff,32'h0,1'b0}, '{1'b0,12'h304,32'h0,32'h4000_0888,1'b0},
      '{1'b1,12'h301,32'h0,32'h0,1'b0}, '{1'b0,12'h301,32'h0,32'h4000_1104,1'b0},
      '{1'b1,12'h344,32'hffff_ffff,32'h0,1'b1}, '{1'b0,12'h344,32'h0,32'h0,1'b0},
      '{1'b1,12'hf11,32'h0,32'h0,1'b1}, '{1'b0,12'hf14,32'h0,32'h0,1'b0},
      '{1'b0,12'hfc0,32'h0,32'h1357_9bdf,1'b0}, '{1'b1,12'hfc8,32'h0,32'h0,1'b1},
      '{1'b0,12'hfc8,32'h0,32'h2468_ace0,1'b0}, '{1'b0,12'h7c4,32'h0,32'h0,1'b1},
      '{1'b1,12'h7cb,32'h1,32'h0,1'b1}, '{1'b0,12'h123,32'h0,32'h0,1'b1},
      '{1'b1,12'h7c0,32'ha5a5_a5a5,32'h0,1'b0}, '{1'b0,12'h7c0,32'h0,32'ha5a5_a5a5,1'b0},
      '{1'b1,12'hbcc,32'h5a5a_5a5a,32'h0,1'b0}, '{1'b0,12'hbcc,32'h0,32'h5a5a_5a5a,1'b0},
      '{1'b0,12'h7f9,32'h0,32'h0007_0000,1'b0}, '{1'b1,12'h7f9,32'hffff_ffff,32'h0,1'b0},
      '{1'b0,12'h7f9,32'h0,32'h0007_05fd,1'b0}};
   logic [31:0] ien [0:2] = '{32'h0000_0080, 32'h0000_0800, 32'h4000_0000};
   logic [31:0] icause [0:2] = '{32'h8000_0007, 32'h8000_000b, 32'h8000_001e};
   logic [3:0]  xcode [0:7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hb};
   logic [4:0]  nev [0:3] = '{5'h10, 5'h08, 5'h04, 5'h18};
   logic [31:0] ncause [0:3] = '{32'h0, 32'hf000_0000, 32'hf000_0001, 32'h0};
   ccsr_bank i_ccsr_bank (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .csr_req_i(csr_req_i),
      .csr_we_i(csr_we_i), .csr_addr_i(csr_addr_i), .csr_wdata_i(csr_wdata_i),
      .debug_mode_i(debug_mode_i), .csr_ack_o(csr_ack_o), .csr_rdata_o(csr_rdata_o),
      .csr_illegal_o(csr_illegal_o), .timer_irq_i(irq_src[0]), .ext_irq_i(irq_src[1]),
      .ce_irq_i(irq_src[2]), .irq_req_o(irq_req_o), .irq_take_i(evt[0]),
      .exc_valid_i(evt[1]), .exc_code_i(code), .nmi_pin_i(evt[4]),
      .nmi_store_err_i(evt[3]), .nmi_load_err_i(evt[2]), .bus_err_addr_i(berr),
      .irq_handler_ptr_i(hptr), .clk_gate_override_o(clk_gate_override_o),
      .feature_disable_o(feature_disable_o), .dma_qos_o(dma_qos_o));
   ccsr_pipe_model i_ccsr_pipe_model (.mclk_i(mclk_i), .csr_ack_i(csr_ack_o),
      .csr_rdata_i(csr_rdata_o), .csr_illegal_i(csr_illegal_o), .csr_req_o(csr_req_i),
      .csr_we_o(csr_we_i), .csr_addr_o(csr_addr_i), .csr_wdata_o(csr_wdata_i));
   // ********
   // Helpers
   // ********
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d);
      i_ccsr_pipe_model.access(we, a, d, rd, ill);
   endtask
   task automatic fire(input logic [4:0] v, input logic [3:0] c);
      @(posedge mclk_i);
      evt  <= v;
      code <= c;
      @(posedge mclk_i);
      evt  <= 5'h0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ********
   // Sequence
   // ********
   initial begin
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (3000) @(posedge mclk_i);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      foreach (rows[i]) begin
         acc(rows[i].we, rows[i].a, rows[i].d);
         chk1("illegal", rows[i].ill, ill);
         if (!rows[i].we)
            chk32("rdata", rows[i].q, rd);
      end
      acc(1'b1, 12'h304, 32'h0000_0008);
      irq_src <= 3'h7;
      repeat (2) @(posedge mclk_i);
      chk1("irq_req", 1'b0, irq_req_o);
      acc(1'b0, 12'h344, 32'h0);
      chk32("pending", 32'h4000_0880, rd);
      for (int k = 0; k < 3; k++) begin
         acc(1'b1, 12'h304, ien[k]);
         chk1("irq_req", 1'b1, irq_req_o);
         fire(5'h01, 4'h0);
         acc(1'b0, 12'h342, 32'h0);
         chk32("cause", icause[k], rd);
      end
      irq_src <= 3'h0;
      foreach (xcode[k]) begin
         fire(5'h02, xcode[k]);
         acc(1'b0, 12'h342, 32'h0);
         chk32("cause", {28'h0, xcode[k]}, rd);
      end
      fire(5'h02, 4'h8);
      acc(1'b0, 12'h342, 32'h0);
      chk32("cause", 32'h0000_000b, rd);
      foreach (nev[k]) begin
         fire(nev[k], 4'h0);
         acc(1'b0, 12'h342, 32'h0);
         chk32("cause", ncause[k], rd);
      end
      fire(5'h01, 4'h0);
      acc(1'b0, 12'h342, 32'h0);
      chk32("cause", 32'h0, rd);
      debug_mode_i <= 1'b1;
      acc(1'b1, 12'h7c9, 32'h0000_55aa);
      acc(1'b0, 12'h7c9, 32'h0);
      chk32("debug rdata", 32'h0000_55aa, rd);
      debug_mode_i <= 1'b0;
      acc(1'b1, 12'h7f8, 32'h0000_00a5);
      chk32("gate", 32'h0000_00a5, {23'h0, clk_gate_override_o});
      acc(1'b1, 12'h7f9, 32'h0000_0000);
      chk32("qos", 32'h0, {29'h0, dma_qos_o});
      rst_b_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk32("gate", 32'h0, {23'h0, clk_gate_override_o});
      chk32("feature", 32'h0007_0000, feature_disable_o);
      chk32("qos", 32'h7, {29'h0, dma_qos_o});
      rst_b_i <= 1'b1;
      acc(1'b0, 12'h7f8, 32'h0);
      chk32("gate read", 32'h0, rd);
      report_and_stop();
   end
endmodule
bind ccsr_bank ccsr_bank_sva i_ccsr_bank_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
   .csr_req_i(csr_req_i), .csr_we_i(csr_we_i), .csr_addr_i(csr_addr_i),
   .csr_wdata_i(csr_wdata_i), .debug_mode_i(debug_mode_i), .csr_ack_o(csr_ack_o),
   .csr_rdata_o(csr_rdata_o), .csr_illegal_o(csr_illegal_o), .timer_irq_i(timer_irq_i),
   .ext_irq_i(ext_irq_i), .ce_irq_i(ce_irq_i), .irq_req_o(irq_req_o),
   .clk_gate_override_o(clk_gate_override_o), .feature_disable_o(feature_disable_o),
   .dma_qos_o(dma_qos_o));
`default_nettype wire
